// file: meter_seq_regs.svh
// constants and rule summary for the meter init and reconfiguration sequencer
// Operation
// - after power-up stay in initialization for 500 us before accepting setup
// - during initialization toggle interrupt output at low-power oscillator rate
// - on adc start wait 1.5 ms stabilisation, first interrupt one period later
// - status register clears only when the host reads it; the code also rewrites bit 1 at each interrupt
// - channel data updates after the data-stable interval following an interrupt
// - only four clock/chop/decimation combinations valid; period is over 2*chop
// - writing zero to bit 7 of reset register 0x09 soft-resets the device
// - soft reset enters initialization and returns reset bit 6 to one
// - soft-reset initialization lasts 500 us with same interrupt toggling
// - gain changes live; first sample after a gain change is invalid
// - normal mode accepts live writes to 0x17, 0x13, 0x15 and 0x18
// - data ready is signalled by an interrupt on the interrupt output
`ifndef METER_SEQ_REGS_SVH
`define METER_SEQ_REGS_SVH
`define ADDR_SOFT_RESET 8'h09
`define ADDR_GAIN 8'h13
`define ADDR_BYPASS 8'h15
`define ADDR_VCH_SEL 8'h17
`define ADDR_ISRC 8'h18
`define ADDR_MODE_CTL 8'h0a
`define ADDR_STATUS 8'h0b
`define ADDR_DATA_LO 8'h0c
`define ADDR_DATA_HI 8'h0d
`define ADDR_TIMING 8'h0e
`define MODE_RUN_BIT 0
`define MODE_STOP_BIT 1
`define RST_SOFT_BIT 7
`define RST_DONE_BIT 6
`define ST_DRDY_BIT 0
`define ST_GAIN_INV_BIT 1
`define ST_LATE_BIT 2
`define RST_RESET_VAL 8'hc0
`define CLK_HZ 200000000
`define INIT_TIME_US 500
`define STAB_TIME_US 1500
`define LPO_HALF_CYCLES 382
`define DIV_1US_CYCLES 200
`define T_INVALID_US 8
`define T_ADC_US_2K 1000
`define T_ADC_US_4K 500
`define T_RD_US_A 96
`define T_RD_US_B 176
`define T_RD_US_C 48
`endif

// file: meter_seq_pkg.sv
// types of the meter init and reconfiguration sequencer
package meter_seq_pkg;
  typedef enum {ST_INIT, ST_STOP, ST_STAB, ST_CONV} seq_state_t;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;
  typedef struct packed {
    logic [15:0] sample;
    logic valid;
  } sample_t;
endpackage

// file: us_counter.sv
// microsecond down counter with terminal pulse
`timescale 1ns/1ps
module us_counter (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic tick_i,
  input wire logic load_i,
  input wire logic [10:0] value_i,
  output logic done_o,
  output logic [10:0] count_o
);
  logic [10:0] cnt_reg;
  logic [10:0] cnt_next;
  logic done_reg;
  logic done_next;

  always_comb begin
    cnt_next = cnt_reg;
    done_next = 1'b0;
    if (load_i) begin
      cnt_next = value_i;
    end else if (tick_i && cnt_reg != 11'h000) begin
      cnt_next = cnt_reg - 11'h001;
      done_next = (cnt_reg == 11'h001);
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      cnt_reg <= 11'h000;
      done_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      done_reg <= done_next;
    end
  end

  assign done_o = done_reg;
  assign count_o = cnt_reg;
endmodule // us_counter

// file: meter_init_and_reconfig_sequencer.sv
// sequencer top: init, stabilisation, conversion timing and register port
`timescale 1ns/1ps
`include "meter_seq_regs.svh"
module meter_init_and_reconfig_sequencer (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire meter_seq_pkg::reg_req_t req_i,
  input wire meter_seq_pkg::sample_t adc_i,
  output logic [7:0] rdata_o,
  output logic int_o,
  output logic init_busy_o,
  output logic cfg_err_o,
  output logic [7:0] gain_o,
  output logic [7:0] bypass_o,
  output logic [7:0] vch_sel_o,
  output logic [7:0] isrc_o
);
  // ****************************************
  // time base
  // ****************************************
  localparam logic [7:0] DIV_LAST = 8'(`DIV_1US_CYCLES - 1);
  localparam logic [8:0] LPO_LAST = 9'(`LPO_HALF_CYCLES - 1);
  logic [7:0] div_reg, div_next;
  logic tick_us;
  logic [8:0] lpo_reg, lpo_next;
  logic lpo_reg_out, lpo_out_next;

  // ****************************************
  // sequence state
  // ****************************************
  meter_seq_pkg::seq_state_t state_reg, state_next;
  logic [7:0] rst_reg, rst_next;
  logic [7:0] mode_reg, mode_next;
  logic [7:0] status_reg, status_next;
  logic [7:0] gain_reg, gain_next;
  logic [7:0] bypass_reg, bypass_next;
  logic [7:0] vch_reg, vch_next;
  logic [7:0] isrc_reg, isrc_next;
  logic [7:0] timing_reg, timing_next;
  logic [15:0] data_reg, data_next;
  logic [7:0] rdata_reg, rdata_next;
  logic int_reg, int_next;
  logic gain_pend_reg, gain_pend_next;
  logic upd_pend_reg, upd_pend_next;
  logic err_reg, err_next;
  logic gap_reg, gap_next;
  logic por_arm_reg;
  logic load_main, load_upd;
  logic [10:0] main_val, upd_val;
  logic main_done, upd_done;
  logic [10:0] upd_cnt;
  logic [10:0] t_adc, t_rd, t_valid;
  logic soft_rst, is_live, wr_ok;

  always_comb begin
    // restart the divider on every timer load, so a span never loses part of a microsecond
    div_next = (div_reg == DIV_LAST || load_main) ? 8'h00 : div_reg + 8'h01;
    lpo_next = (lpo_reg == LPO_LAST) ? 9'h000 : lpo_reg + 9'h001;
    lpo_out_next = (lpo_reg == LPO_LAST) ? ~lpo_reg_out : lpo_reg_out;
  end
  assign tick_us = (div_reg == DIV_LAST);

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      div_reg <= 8'h00;
      lpo_reg <= 9'h000;
      lpo_reg_out <= 1'b0;
    end else begin
      div_reg <= div_next;
      lpo_reg <= lpo_next;
      lpo_reg_out <= lpo_out_next;
    end
  end

  // ****************************************
  // conversion timing selection
  // ****************************************
  // timing bits: [1:0] combination index (0..3), only valid combos exist
  always_comb begin
    t_adc = 11'(`T_ADC_US_2K);
    t_rd = 11'(`T_RD_US_A);
    case (timing_reg[1:0])
      2'h1: t_rd = 11'(`T_RD_US_B);
      2'h3: begin
        t_adc = 11'(`T_ADC_US_4K);
        t_rd = 11'(`T_RD_US_C);
      end
      default: t_rd = 11'(`T_RD_US_A);
    endcase
    t_valid = t_adc - 11'(`T_INVALID_US);
  end

  // ****************************************
  // timers
  // ****************************************
  us_counter main_timer (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .tick_i(tick_us),
    .load_i(load_main),
    .value_i(main_val),
    .done_o(main_done),
    .count_o()
  );

  us_counter update_timer (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .tick_i(tick_us),
    .load_i(load_upd),
    .value_i(upd_val),
    .done_o(upd_done),
    .count_o(upd_cnt)
  );

  assign soft_rst = req_i.wr && req_i.addr == `ADDR_SOFT_RESET
    && !req_i.wdata[`RST_SOFT_BIT] && state_reg != meter_seq_pkg::ST_INIT;
  assign is_live = req_i.addr == `ADDR_GAIN || req_i.addr == `ADDR_BYPASS
    || req_i.addr == `ADDR_VCH_SEL || req_i.addr == `ADDR_ISRC
    || req_i.addr == `ADDR_MODE_CTL || req_i.addr == `ADDR_SOFT_RESET;
  // writes during init are dropped
  assign wr_ok = req_i.wr && state_reg != meter_seq_pkg::ST_INIT;

  // ****************************************
  // sequencer and registers
  // ****************************************
  always_comb begin
    state_next = state_reg;
    rst_next = rst_reg;
    mode_next = mode_reg;
    status_next = status_reg;
    gain_next = gain_reg;
    bypass_next = bypass_reg;
    vch_next = vch_reg;
    isrc_next = isrc_reg;
    timing_next = timing_reg;
    data_next = data_reg;
    int_next = 1'b0;
    gain_pend_next = gain_pend_reg;
    upd_pend_next = upd_pend_reg;
    gap_next = gap_reg;
    err_next = err_reg;
    load_main = 1'b0;
    main_val = t_adc;
    load_upd = 1'b0;
    upd_val = t_valid;
    rdata_next = rdata_reg;
    if (req_i.rd) begin
      case (req_i.addr)
        `ADDR_SOFT_RESET: rdata_next = rst_reg;
        `ADDR_MODE_CTL: rdata_next = mode_reg;
        `ADDR_STATUS: rdata_next = status_reg;
        `ADDR_GAIN: rdata_next = gain_reg;
        `ADDR_BYPASS: rdata_next = bypass_reg;
        `ADDR_VCH_SEL: rdata_next = vch_reg;
        `ADDR_ISRC: rdata_next = isrc_reg;
        `ADDR_DATA_LO: rdata_next = data_reg[7:0];
        `ADDR_DATA_HI: rdata_next = data_reg[15:8];
        `ADDR_TIMING: rdata_next = timing_reg;
        default: rdata_next = 8'h00;
      endcase
      if (req_i.addr == `ADDR_STATUS)
        status_next = 8'h00; // clear on host read; the gain-invalid bit is also rewritten at each interrupt
      // late or gap reads are flagged after the clear, so a set in the same cycle wins
      if (state_reg == meter_seq_pkg::ST_CONV && (req_i.addr == `ADDR_STATUS
          || req_i.addr == `ADDR_DATA_LO || req_i.addr == `ADDR_DATA_HI)
          && (gap_reg || (upd_pend_reg && upd_cnt < t_valid - t_rd)))
        status_next[`ST_LATE_BIT] = 1'b1;
    end
    if (wr_ok && !soft_rst) begin
      if (state_reg == meter_seq_pkg::ST_CONV && !is_live) begin
        err_next = 1'b1; // non-live register write while running is refused
      end else begin
        case (req_i.addr)
          `ADDR_GAIN: begin
            gain_next = req_i.wdata;
            gain_pend_next = (state_reg == meter_seq_pkg::ST_CONV);
          end
          `ADDR_BYPASS: bypass_next = req_i.wdata;
          `ADDR_VCH_SEL: vch_next = req_i.wdata;
          `ADDR_ISRC: isrc_next = req_i.wdata;
          `ADDR_TIMING: timing_next = {6'h00, req_i.wdata[1:0]};
          `ADDR_MODE_CTL: mode_next = req_i.wdata & 8'h03;
          default: err_next = err_reg;
        endcase
      end
    end
    case (state_reg)
      meter_seq_pkg::ST_INIT: begin
        if (main_done) begin
          state_next = meter_seq_pkg::ST_STOP; // init over
        end
      end
      meter_seq_pkg::ST_STOP: begin
        if (mode_reg[`MODE_RUN_BIT] && !mode_reg[`MODE_STOP_BIT]) begin
          state_next = meter_seq_pkg::ST_STAB;
          load_main = 1'b1;
          main_val = 11'(`STAB_TIME_US); // settle before conversions
        end
      end
      meter_seq_pkg::ST_STAB: begin
        if (mode_reg[`MODE_STOP_BIT]) begin
          state_next = meter_seq_pkg::ST_STOP;
        end else if (main_done) begin
          state_next = meter_seq_pkg::ST_CONV;
          load_main = 1'b1; // first interrupt one period later
        end
      end
      meter_seq_pkg::ST_CONV: begin
        if (mode_reg[`MODE_STOP_BIT]) begin
          state_next = meter_seq_pkg::ST_STOP;
          upd_pend_next = 1'b0;
          gap_next = 1'b0;
        end else begin
          if (main_done) begin
            load_main = 1'b1;
            gap_next = 1'b0;
            load_upd = 1'b1;
            upd_pend_next = 1'b1;
            int_next = 1'b1; // data ready interrupt
            status_next[`ST_DRDY_BIT] = 1'b1;
            status_next[`ST_GAIN_INV_BIT] = gain_pend_reg;
            gain_pend_next = 1'b0;
          end
          if (upd_done) begin
            data_next = adc_i.sample; // update after stable interval
            upd_pend_next = 1'b0;
            gap_next = 1'b1; // update gap until the next interrupt
          end
        end
      end
      default: state_next = meter_seq_pkg::ST_INIT;
    endcase
    if (soft_rst) begin
      state_next = meter_seq_pkg::ST_INIT;
      rst_next = `RST_RESET_VAL;
      mode_next = 8'h00;
      load_main = 1'b1;
      main_val = 11'(`INIT_TIME_US);
      upd_pend_next = 1'b0;
      gain_pend_next = 1'b0;
      gap_next = 1'b0;
    end
    if (por_arm_reg) begin
      load_main = 1'b1; // power-on init timer start
      main_val = 11'(`INIT_TIME_US);
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      state_reg <= meter_seq_pkg::ST_INIT;
      rst_reg <= `RST_RESET_VAL;
      mode_reg <= 8'h00;
      status_reg <= 8'h00;
      gain_reg <= 8'h00;
      bypass_reg <= 8'h00;
      vch_reg <= 8'h00;
      isrc_reg <= 8'h00;
      timing_reg <= 8'h00;
      data_reg <= 16'h0000;
      rdata_reg <= 8'h00;
      int_reg <= 1'b0;
      gain_pend_reg <= 1'b0;
      upd_pend_reg <= 1'b0;
      err_reg <= 1'b0;
      gap_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      rst_reg <= rst_next;
      mode_reg <= mode_next;
      status_reg <= status_next;
      gain_reg <= gain_next;
      bypass_reg <= bypass_next;
      vch_reg <= vch_next;
      isrc_reg <= isrc_next;
      timing_reg <= timing_next;
      data_reg <= data_next;
      rdata_reg <= rdata_next;
      int_reg <= int_next;
      gain_pend_reg <= gain_pend_next;
      upd_pend_reg <= upd_pend_next;
      err_reg <= err_next;
      gap_reg <= gap_next;
    end
  end

  // power-on init: timer loads on the first cycle after reset release
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      por_arm_reg <= 1'b1;
    end else begin
      por_arm_reg <= 1'b0;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  // init toggles follow the low-power oscillator rate
  assign int_o = (state_reg == meter_seq_pkg::ST_INIT) ? lpo_reg_out : int_reg;
  assign init_busy_o = (state_reg == meter_seq_pkg::ST_INIT);
  assign rdata_o = rdata_reg;
  assign cfg_err_o = err_reg;
  assign gain_o = gain_reg;
  assign bypass_o = bypass_reg;
  assign vch_sel_o = vch_reg;
  assign isrc_o = isrc_reg;
endmodule // meter_init_and_reconfig_sequencer

// file: meter_seq_props.sv
// checker: timing relations at the sequencer ports
`timescale 1ns/1ps
`include "meter_seq_regs.svh"
module meter_seq_props (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire meter_seq_pkg::reg_req_t req_i,
  input wire logic int_o,
  input wire logic init_busy_o,
  input wire logic cfg_err_o,
  input wire logic [7:0] gain_o
);
  // ****************
  // helper counters
  // ****************
  logic [16:0] init_reg, init_next;
  logic [9:0] tog_reg, tog_next;
  logic int_reg, int_next;
  always_comb begin
    init_next = init_busy_o ? init_reg + 17'h1 : 17'h0;
    tog_next = (!init_busy_o || int_o != int_reg) ? 10'h0 : tog_reg + 10'h1;
    int_next = int_o;
  end
  always_ff @(posedge clk_sys_i) begin
    init_reg <= rst_n_i ? init_next : 17'h0;
    tog_reg <= rst_n_i ? tog_next : 10'h0;
    int_reg <= rst_n_i ? int_next : 1'b0;
  end
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  chk_init_max: assert property (init_reg <= 17'h186a5)
    else $error("initialization too long");
  chk_init_min: assert property ($fell(init_busy_o) |-> init_reg >= 17'h1869b)
    else $error("initialization too short");
  chk_init_toggle: assert property (init_busy_o |-> tog_reg <= 10'h180)
    else $error("interrupt line not toggling in init");
  chk_init_wr_ignored: assert property (init_busy_o && req_i.wr && req_i.addr == `ADDR_GAIN
    |=> $stable(gain_o))
    else $error("write taken during init");
  chk_soft_reset: assert property (!init_busy_o && req_i.wr && req_i.addr == `ADDR_SOFT_RESET
    && !req_i.wdata[`RST_SOFT_BIT] |=> ##[0:2] init_busy_o)
    else $error("soft reset did not enter init");
  chk_live_gain: assert property (!init_busy_o && req_i.wr && req_i.addr == `ADDR_GAIN
    |=> gain_o == $past(req_i.wdata))
    else $error("gain write not applied");
  chk_cfg_sticky: assert property (cfg_err_o |=> cfg_err_o)
    else $error("config error flag dropped");
  chk_int_pulse: assert property (!init_busy_o && !$past(init_busy_o) && int_o
    |=> !int_o)
    else $error("data ready pulse too long");
  chk_stab_quiet: assert property (!init_busy_o && req_i.wr && req_i.addr == `ADDR_MODE_CTL
    && req_i.wdata[`MODE_RUN_BIT] |=> !int_o [*8])
    else $error("interrupt during stabilisation");
endmodule // meter_seq_props
bind meter_init_and_reconfig_sequencer meter_seq_props u_meter_seq_props (
  .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .req_i(req_i), .int_o(int_o),
  .init_busy_o(init_busy_o), .cfg_err_o(cfg_err_o), .gain_o(gain_o));

// file: host_model.sv
// host model: register requests as the microcontroller issues them
`timescale 1ns/1ps
module host_model (
  input wire logic clk_sys_i,
  output meter_seq_pkg::reg_req_t req_o
);
  initial req_o = '0;
  // held one full cycle; released address and data show the inverse so stale values never match
  task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys_i);
    req_o = {w, !w, a, d};
    @(negedge clk_sys_i);
    req_o = {2'b00, ~a, ~d};
  endtask
endmodule // host_model

// file: testbench.sv
// self-checking bench of the meter init and reconfiguration sequencer
`timescale 1ns/1ps
`include "meter_seq_regs.svh"
module testbench;
  logic clk_sys_i = 1'b0;
  logic rst_n_i = 1'b0;
  meter_seq_pkg::reg_req_t req;
  meter_seq_pkg::sample_t adc = '0;
  logic [7:0] rdata, gain, g;
  logic [15:0] smp;
  logic int_w, busy, cfg_err, rd_seen = 1'b0;
  logic [31:0] lfsr_reg = 32'h3dd5f036;
  logic [7:0] exp_q[$];
  int error_cnt = 0;
  int n_checks = 0;
  int cyc, tog;
  always #2.5 clk_sys_i = ~clk_sys_i;
  host_model u_host_model (.clk_sys_i(clk_sys_i), .req_o(req));
  meter_init_and_reconfig_sequencer u_meter_init_and_reconfig_sequencer (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .req_i(req), .adc_i(adc), .rdata_o(rdata),
    .int_o(int_w), .init_busy_o(busy), .cfg_err_o(cfg_err), .gain_o(gain), .bypass_o(),
    .vch_sel_o(), .isrc_o());
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // the sample is held for whole periods, so the captured value is known
  always @(negedge clk_sys_i) begin
    lfsr_reg = lfsr(lfsr_reg);
  end
  task automatic check(input string w, input logic [7:0] e, input logic [7:0] s);
    n_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", w, e, s);
    end
  endtask
  task automatic span(input string w, input int v, input int lo, input int hi);
    n_checks++;
    if (v < lo || v > hi) begin
      error_cnt++;
      $display("unexpected %s expected %0d..%0d seen %0d", w, lo, hi, v);
    end
  endtask
  // ****************
  // read result watcher
  // ****************
  always @(posedge clk_sys_i) rd_seen <= req.rd;
  always @(negedge clk_sys_i) if (rd_seen) check("rdata_o", exp_q.pop_front(), rdata);
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    u_host_model.access(1'b0, a, 8'h00);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    u_host_model.access(1'b1, a, d);
  endtask
  // m=0 waits for init to end, m=1 for a data ready pulse
  task automatic wait_for(input logic m, input int lim);
    logic p;
    p = int_w;
    cyc = 0;
    tog = 0;
    do begin
      @(negedge clk_sys_i);
      cyc++;
      if (int_w !== p) tog++;
      p = int_w;
    end while ((m ? int_w : ~busy) !== 1'b1 && cyc < lim);
  endtask
  task automatic test_done;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    #6000000;
    error_cnt++;
    test_done();
  end
  initial begin
    repeat (4) @(negedge clk_sys_i);
    rst_n_i = 1'b1;
    check("init_busy_o", 8'h01, {7'h0, busy});
    wr(`ADDR_GAIN, 8'h5a);
    wait_for(1'b0, 101000);
    span("init cycles", cyc, 99985, 100005);
    span("init toggles", tog, 255, 265);
    check("gain_o", 8'h00, gain);
    wr(`ADDR_SOFT_RESET, 8'h00);
    @(negedge clk_sys_i);
    check("init_busy_o", 8'h01, {7'h0, busy});
    wait_for(1'b0, 101000);
    span("soft init cycles", cyc, 99985, 100005);
    span("soft init toggles", tog, 255, 265);
    rd(`ADDR_SOFT_RESET, `RST_RESET_VAL);
    wr(`ADDR_TIMING, 8'h03);
    wr(`ADDR_MODE_CTL, 8'h01);
    wait_for(1'b1, 401000);
    span("first int", cyc, 399990, 400010);
    smp = lfsr_reg[15:0];
    adc.sample = smp;
    rd(`ADDR_STATUS, 8'h01);
    rd(`ADDR_STATUS, 8'h00);
    g = lfsr_reg[7:0];
    wr(`ADDR_GAIN, g);
    check("gain_o", g, gain);
    wait_for(1'b1, 101000);
    span("period", cyc, 99980, 100005);
    rd(`ADDR_STATUS, 8'h03);
    rd(`ADDR_DATA_LO, smp[7:0]);
    rd(`ADDR_DATA_HI, smp[15:8]);
    wait_for(1'b1, 101000);
    rd(`ADDR_STATUS, 8'h01);
    repeat (12000) @(negedge clk_sys_i);
    rd(`ADDR_STATUS, 8'h00);
    rd(`ADDR_STATUS, 8'h04);
    wr(`ADDR_TIMING, 8'h00);
    check("cfg_err_o", 8'h01, {7'h0, cfg_err});
    wr(`ADDR_MODE_CTL, 8'h02);
    repeat (2) @(negedge clk_sys_i);
    test_done();
  end
endmodule // testbench
